// File: verilog/asr_core.sv
// Operation
// RL1: Transmit 8 or 9 data bits; ninth bit comes from tx_ninth_bit.
// RL2: Software enables block, then transmitter, then reads status_one and writes data.
// RL3: Each transmission begins with an all-ones preamble before the data word; the code sends one only after tx_on rises or the block is enabled with tx_on set.
// RL4: Loaded frame has start 0 at the LSB, stop 1 at the MSB.
// RL5: Buffer hand-off sets tx_buffer_empty; with its enable, a transmit request follows.
// RL6: Serial output rests at 1 whenever no character is shifting.
// RL7: Clearing block_enable releases transmit and receive pins.
// RL8: While send_break is 1, all-zero break characters of frame length repeat.
// RL9: After send_break clears, finish the break and send at least one 1.
// RL10: Start, all-zero data and zero stop bit is received as a break.
// RL11: A break sets framing, full and break flags and clears data and ninth bit.
// RL12: Idle character is all ones of frame length; the preamble is one.
// RL13: Dropping tx_on mid-character finishes that character, then idles.
// RL14: Clearing then setting tx_on mid-character queues one idle character.
// RL15: Software re-enables the transmitter before the current stop bit leaves.
// RL16: tx_polarity_flip inverts every transmitted level.
// RL17: tx_done_flag shows all empty and no break or idle; its enable gates request.
// RL18: Receive 8 or 9 bits; rx_ninth_bit holds bit 8, or bit 7 copy.
// RL19: A full character moves to the buffer and sets rx_full_flag, gated request.
// RL20: Data address writes feed the transmitter and reads return received data.
// RL21: Receiver samples on a tick at sixteen times the baud rate.
// RL22: Missing stop bit sets framing error together with rx_full_flag.
// RL23: Data bits travel least significant bit first between start and stop.
// RL24: One shared baud generator; transmitter and receiver otherwise independent.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "asr_consts.svh"

module asr_core #(
    parameter int ADDR_W = 8,
    parameter int DIV_W  = 16
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              serial_in_pin,
    output logic                   serial_in_en,
    output logic                   serial_out_pin,
    output logic                   serial_out_oe,
    output logic                   tx_irq,
    output logic                   rx_irq
);
    import asr_pkg::*;

    if (ADDR_W < 8 || ADDR_W > 32 || DIV_W < 2 || DIV_W > 16) begin : g_bad_param
        $error("asr_core: unsupported ADDR_W or DIV_W");
    end

    function automatic logic hit(input logic [ADDR_W-3:0] a, input logic [5:0] idx);
        return a == (ADDR_W-2)'(idx);
    endfunction : hit

    asr_ctrl_t         ctrl_ff;
    asr_rx_st_t        rx_st_ff;
    logic [DIV_W-1:0]  baud_ff, div_cnt_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [10:0]       tx_sh_ff;
    logic [8:0]        rx_sh_ff;
    logic [7:0]        wbyte_ff, txbuf_ff, rxbuf_ff;
    logic [3:0]        tx_cnt_ff, tx_ph_ff, rx_ph_ff, rx_bit_ff;
    logic              aw_got_ff, w_got_ff, wlane_ff, tx_arm_ff, rx_arm_ff, brk_arm_ff;
    logic              tx_empty_ff, tx_done_ff, te_prev_ff, pre_pend_ff, tail_pend_ff;
    logic              line_prev_ff, r8_ff, rx_full_ff, ovr_ff, fe_ff, brk_ff;

    // Bus decode
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire  = s_axi_wvalid & s_axi_wready;
    wire ar_fire = s_axi_arvalid & s_axi_arready;
    wire wr_do   = aw_got_ff & w_got_ff & ~s_axi_bvalid;
    wire [ADDR_W-3:0] aw_i = awaddr_ff[ADDR_W-1:2];
    wire [ADDR_W-3:0] ar_i = s_axi_araddr[ADDR_W-1:2];
    wire wr_ok  = wr_do & wlane_ff;
    wire wr_c1  = wr_ok & hit(aw_i, `ASR_IDX_CTRL1);
    wire wr_c2  = wr_ok & hit(aw_i, `ASR_IDX_CTRL2);
    wire wr_c3  = wr_ok & hit(aw_i, `ASR_IDX_CTRL3);
    wire wr_dat = wr_ok & hit(aw_i, `ASR_IDX_DATA);
    wire wr_bd  = wr_ok & hit(aw_i, `ASR_IDX_BAUD);
    wire aw_map = (aw_i >= (ADDR_W-2)'(`ASR_IDX_CTRL1)) & (aw_i <= (ADDR_W-2)'(`ASR_IDX_BAUD));
    wire rd_s1  = ar_fire & hit(ar_i, `ASR_IDX_STAT1);
    wire rd_s2  = ar_fire & hit(ar_i, `ASR_IDX_STAT2);
    wire rd_dat = ar_fire & hit(ar_i, `ASR_IDX_DATA);

    wire [7:0] c1_rd = {1'b0, ctrl_ff.en, ctrl_ff.flip, ctrl_ff.nine, 4'h0};
    wire [7:0] c2_rd = {ctrl_ff.tie, ctrl_ff.tx_done_irq_en, ctrl_ff.rie, 1'b0,
                        ctrl_ff.te, ctrl_ff.re, 1'b0, ctrl_ff.send_break};
    wire [7:0] c3_rd = {r8_ff, ctrl_ff.t8, 6'h00};
    wire [7:0] s1_rd = {tx_empty_ff, tx_done_ff, rx_full_ff, 1'b0,
                        ovr_ff, 1'b0, fe_ff, 1'b0};
    wire [7:0] s2_rd = {6'h00, brk_ff, rx_st_ff != RX_IDLE};
    wire       rd_ok = (ar_i >= (ADDR_W-2)'(`ASR_IDX_CTRL1)) &
                       (ar_i <= (ADDR_W-2)'(`ASR_IDX_BAUD));
    wire [31:0] rd_mux =
        hit(ar_i, `ASR_IDX_CTRL1) ? {24'h000000, c1_rd} :
        hit(ar_i, `ASR_IDX_CTRL2) ? {24'h000000, c2_rd} :
        hit(ar_i, `ASR_IDX_CTRL3) ? {24'h000000, c3_rd} :
        hit(ar_i, `ASR_IDX_STAT1) ? {24'h000000, s1_rd} :
        hit(ar_i, `ASR_IDX_STAT2) ? {24'h000000, s2_rd} :
        hit(ar_i, `ASR_IDX_DATA)  ? {24'h000000, rxbuf_ff} : // RL20
        hit(ar_i, `ASR_IDX_BAUD)  ? 32'(baud_ff) : 32'h00000000;

    // Baud and sample tick, shared by both directions
    wire rt_tick  = ctrl_ff.en & (div_cnt_ff == baud_ff); // RL21 RL24
    wire bit_tick = rt_tick & (tx_ph_ff == `ASR_PH_LAST);
    wire tx_run   = ctrl_ff.en & ctrl_ff.te;
    wire rx_run   = ctrl_ff.en & ctrl_ff.re;
    wire [3:0] frm_len = ctrl_ff.nine ? `ASR_LEN9 : `ASR_LEN8;
    wire [3:0] rx_last = ctrl_ff.nine ? `ASR_BITS9 : `ASR_BITS8;
    wire [10:0] tx_frame = ctrl_ff.nine ?
        {1'b1, ctrl_ff.t8, txbuf_ff, 1'b0} : {2'b11, txbuf_ff, 1'b0}; // RL1 RL4 RL23
    wire tx_busy = tx_cnt_ff != 4'h0;
    wire tx_load = bit_tick & (tx_cnt_ff <= 4'h1);
    wire rx_mid  = rt_tick & (rx_ph_ff == `ASR_PH_MID);
    wire rx_end  = rx_run & rx_mid & (rx_st_ff == RX_STOP);
    wire rx_brk  = rx_end & ~serial_in_pin & (rx_sh_ff == 9'h000); // RL10
    wire [7:0] rx_word = ctrl_ff.nine ? rx_sh_ff[7:0] : rx_sh_ff[8:1];

    // Bus slave handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            awaddr_ff     <= '0;
            wbyte_ff      <= 8'h00;
            wlane_ff      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ASR_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ASR_OKAY;
        end else begin
            aw_got_ff     <= aw_fire | (aw_got_ff & ~wr_do);
            w_got_ff      <= w_fire | (w_got_ff & ~wr_do);
            // Refuse new requests until the pending answer is taken
            s_axi_awready <= ~(aw_fire | aw_got_ff) & ~(s_axi_bvalid & ~s_axi_bready);
            s_axi_wready  <= ~(w_fire | w_got_ff) & ~(s_axi_bvalid & ~s_axi_bready);
            if (aw_fire) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_fire) begin
                wbyte_ff <= s_axi_wdata[7:0];
                wlane_ff <= s_axi_wstrb[0];
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_map ? `ASR_OKAY : `ASR_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_ok ? `ASR_OKAY : `ASR_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Control registers and flag-clearing sequences
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff    <= '0;
            baud_ff    <= DIV_W'(`ASR_BAUD_RST);
            txbuf_ff   <= 8'h00;
            tx_arm_ff  <= 1'b0;
            rx_arm_ff  <= 1'b0;
            brk_arm_ff <= 1'b0;
        end else begin
            if (wr_c1) begin
                ctrl_ff.en   <= wbyte_ff[`ASR_C1_EN];
                ctrl_ff.flip <= wbyte_ff[`ASR_C1_FLIP];
                ctrl_ff.nine <= wbyte_ff[`ASR_C1_NINE];
            end
            if (wr_c2) begin
                ctrl_ff.tie  <= wbyte_ff[`ASR_C2_TIE];
                ctrl_ff.tx_done_irq_en <= wbyte_ff[`ASR_C2_TX_DONE_IRQ_EN];
                ctrl_ff.rie  <= wbyte_ff[`ASR_C2_RIE];
                ctrl_ff.te   <= wbyte_ff[`ASR_C2_TE];
                ctrl_ff.re   <= wbyte_ff[`ASR_C2_RE];
                ctrl_ff.send_break  <= wbyte_ff[`ASR_C2_SBK];
            end
            if (wr_c3) begin
                ctrl_ff.t8 <= wbyte_ff[`ASR_C3_T8];
            end
            if (wr_bd) begin
                baud_ff <= DIV_W'(wbyte_ff);
            end
            if (wr_dat) begin
                txbuf_ff <= wbyte_ff; // RL20
            end
            tx_arm_ff  <= rd_s1 | (tx_arm_ff & ~wr_dat);
            rx_arm_ff  <= rd_s1 | (rx_arm_ff & ~rd_dat);
            brk_arm_ff <= rd_s2 | (brk_arm_ff & ~rd_dat);
        end
    end

    // Sample tick divider
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_ff.en || rt_tick) begin
            div_cnt_ff <= '0;
        end else begin
            div_cnt_ff <= div_cnt_ff + DIV_W'(1);
        end
    end

    // Transmitter
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_ff.en) begin
            tx_sh_ff     <= `ASR_TX_IDLE;
            tx_cnt_ff    <= 4'h0;
            tx_ph_ff     <= 4'h0;
            te_prev_ff   <= 1'b0;
            pre_pend_ff  <= 1'b0;
            tail_pend_ff <= 1'b0;
            tx_done_ff   <= !aresetn | tx_empty_ff;
            tx_empty_ff  <= !aresetn | (tx_empty_ff & ~(wr_dat & tx_arm_ff));
        end else begin
            te_prev_ff <= ctrl_ff.te;
            if (rt_tick) begin
                tx_ph_ff <= tx_ph_ff + 4'h1;
            end
            if (wr_dat & tx_arm_ff) begin
                tx_empty_ff <= 1'b0;
            end
            if (ctrl_ff.te & ~te_prev_ff) begin
                pre_pend_ff <= 1'b1; // RL3 RL14
            end
            if (bit_tick & (tx_cnt_ff > 4'h1)) begin
                tx_sh_ff  <= {1'b1, tx_sh_ff[10:1]}; // RL23
                tx_cnt_ff <= tx_cnt_ff - 4'h1;
            end else if (tx_load) begin
                if (!tx_run) begin
                    tx_sh_ff  <= `ASR_TX_IDLE; // RL13
                    tx_cnt_ff <= 4'h0;
                end else if (pre_pend_ff) begin
                    tx_sh_ff    <= `ASR_TX_IDLE; // RL12
                    tx_cnt_ff   <= frm_len;
                    pre_pend_ff <= ctrl_ff.te & ~te_prev_ff;
                end else if (ctrl_ff.send_break) begin
                    tx_sh_ff     <= 11'h000; // RL8
                    tx_cnt_ff    <= frm_len;
                    tail_pend_ff <= 1'b1;
                end else if (tail_pend_ff) begin
                    tx_sh_ff     <= `ASR_TX_IDLE; // RL9
                    tx_cnt_ff    <= 4'h1;
                    tail_pend_ff <= 1'b0;
                end else if (!tx_empty_ff) begin
                    tx_sh_ff    <= tx_frame;
                    tx_cnt_ff   <= frm_len;
                    tx_empty_ff <= 1'b1; // RL5
                end else begin
                    tx_sh_ff  <= `ASR_TX_IDLE;
                    tx_cnt_ff <= 4'h0;
                end
            end
            tx_done_ff <= ~tx_busy & tx_empty_ff & ~pre_pend_ff & ~tail_pend_ff &
                          ~(tx_run & ctrl_ff.send_break); // RL17
        end
    end

    // Receiver
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_st_ff     <= RX_IDLE;
            rx_ph_ff     <= 4'h0;
            rx_bit_ff    <= 4'h0;
            rx_sh_ff     <= 9'h000;
            line_prev_ff <= 1'b0;
        end else if (!rx_run) begin
            rx_st_ff     <= RX_IDLE;
            line_prev_ff <= 1'b0;
        end else if (rt_tick) begin
            rx_ph_ff <= rx_ph_ff + 4'h1;
            unique case (rx_st_ff)
                RX_IDLE: begin
                    line_prev_ff <= serial_in_pin;
                    rx_ph_ff     <= 4'h1;
                    if (line_prev_ff & ~serial_in_pin) begin
                        rx_st_ff <= RX_START;
                        rx_sh_ff <= 9'h000;
                    end
                end
                RX_START: begin
                    if (rx_ph_ff == `ASR_PH_CHK && serial_in_pin) begin
                        rx_st_ff <= RX_IDLE;
                    end else if (rx_ph_ff == `ASR_PH_LAST) begin
                        rx_st_ff  <= RX_DATA;
                        rx_bit_ff <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_ph_ff == `ASR_PH_MID) begin
                        rx_sh_ff <= {serial_in_pin, rx_sh_ff[8:1]}; // RL23
                    end
                    if (rx_ph_ff == `ASR_PH_LAST) begin
                        rx_bit_ff <= rx_bit_ff + 4'h1;
                        if (rx_bit_ff == rx_last) begin
                            rx_st_ff <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_ph_ff == `ASR_PH_MID) begin
                        rx_st_ff     <= RX_IDLE;
                        line_prev_ff <= serial_in_pin;
                    end
                end
            endcase
        end
    end

    // Receive buffer and flags; a new event wins over a clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxbuf_ff   <= 8'h00;
            r8_ff      <= 1'b0;
            rx_full_ff <= 1'b0;
            ovr_ff     <= 1'b0;
            fe_ff      <= 1'b0;
            brk_ff     <= 1'b0;
        end else begin
            if (rd_dat & rx_arm_ff) begin
                rx_full_ff <= 1'b0;
                ovr_ff     <= 1'b0;
                fe_ff      <= 1'b0;
            end
            if (rd_dat & brk_arm_ff) begin
                brk_ff <= 1'b0;
            end
            if (rx_end) begin
                rx_full_ff <= 1'b1; // RL19
                fe_ff      <= ~serial_in_pin | (fe_ff & ~(rd_dat & rx_arm_ff)); // RL22
                if (rx_full_ff & ~(rd_dat & rx_arm_ff)) begin
                    ovr_ff <= 1'b1;
                end else begin
                    rxbuf_ff <= rx_word; // RL19
                    r8_ff    <= rx_sh_ff[8]; // RL18
                end
            end
            if (rx_brk) begin
                rxbuf_ff <= 8'h00; // RL11
                r8_ff    <= 1'b0;
                brk_ff   <= 1'b1;
            end
        end
    end

    // Pins and interrupt requests
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_out_pin <= 1'b1;
            serial_out_oe  <= 1'b0;
            serial_in_en   <= 1'b0;
            tx_irq         <= 1'b0;
            rx_irq         <= 1'b0;
        end else begin
            serial_out_pin <= (tx_busy ? tx_sh_ff[0] : 1'b1) ^ ctrl_ff.flip; // RL6 RL16
            serial_out_oe  <= ctrl_ff.en & (ctrl_ff.te | tx_busy); // RL7
            serial_in_en   <= rx_run; // RL7
            tx_irq <= (ctrl_ff.tie & tx_empty_ff) | (ctrl_ff.tx_done_irq_en & tx_done_ff); // RL5 RL17
            rx_irq <= ctrl_ff.rie & rx_full_ff; // RL19
        end
    end
endmodule : asr_core

// File: verilog/asr_consts.svh
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
// Register indices; byte address is four times the index
`define ASR_IDX_CTRL1  6'h38
`define ASR_IDX_CTRL2  6'h39
`define ASR_IDX_CTRL3  6'h3A
`define ASR_IDX_STAT1  6'h3B
`define ASR_IDX_STAT2  6'h3C
`define ASR_IDX_DATA   6'h3D
`define ASR_IDX_BAUD   6'h3E
// Field positions
`define ASR_C1_EN      6
`define ASR_C1_FLIP    5
`define ASR_C1_NINE    4
`define ASR_C2_TIE     7
`define ASR_C2_TX_DONE_IRQ_EN    6
`define ASR_C2_RIE     5
`define ASR_C2_TE      3
`define ASR_C2_RE      2
`define ASR_C2_SBK     0
`define ASR_C3_T8      6
// Reset values
`define ASR_BAUD_RST   16'h0068
`define ASR_TX_IDLE    11'h7FF
// Timing: sample ticks per bit and the phases that matter
`define ASR_PH_LAST    4'hF
`define ASR_PH_MID     4'h8
`define ASR_PH_CHK     4'h7
`define ASR_LEN8       4'hA
`define ASR_LEN9       4'hB
`define ASR_BITS8      4'h7
`define ASR_BITS9      4'h8
// Bus answers
`define ASR_OKAY       2'h0
`define ASR_SLVERR     2'h2
`endif

// File: verilog/asr_pkg.sv
package asr_pkg;
    typedef struct packed {
        logic en;
        logic flip;
        logic nine;
        logic tie;
        logic tx_done_irq_en;
        logic rie;
        logic te;
        logic re;
        logic send_break;
        logic t8;
    } asr_ctrl_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } asr_rx_st_t;
endpackage : asr_pkg

// File: tb/asr_checker.sv
`timescale 1ns/10ps
module asr_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic              serial_in_pin,
    input wire logic              serial_in_en,
    input wire logic              serial_out_pin,
    input wire logic              serial_out_oe,
    input wire logic              tx_irq,
    input wire logic              rx_irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_b_lat; s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid; endproperty
    a_b_lat: assert property (p_b_lat) else $error("write answer off time");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken while busy");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
    a_b_done: assert property (p_b_done) else $error("write answer not retired");
    property p_r_lat; s_rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer off time");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready; endproperty
    a_r_done: assert property (p_r_done) else $error("read answer not retired");
    property p_r_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
    a_r_byte: assert property (p_r_byte) else $error("upper read bits set");
endmodule : asr_checker

bind asr_core asr_checker #(.ADDR_W(ADDR_W)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .serial_in_pin(serial_in_pin), .serial_in_en(serial_in_en),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe), .tx_irq(tx_irq),
    .rx_irq(rx_irq));

// File: tb/asr_peer.sv
`timescale 1ns/10ps
module asr_peer #(
    parameter int BIT = 32
) (
    input  wire logic aclk,
    input  wire logic from_dut,
    output logic      to_dut
);
    initial to_dut = 1'b1;
    // One bit lasts BIT clocks
    task automatic send(input logic [10:0] f, input int n);
        for (int i = 0; i < n; i++) begin
            to_dut <= f[i];
            repeat (BIT) @(posedge aclk);
        end
        to_dut <= 1'b1;
        repeat (BIT) @(posedge aclk);
    endtask : send
    // Samples mid-bit, undoing the inversion
    task automatic recv(input logic flip, input int n, output logic [10:0] f);
        f = '0;
        @(posedge aclk);
        while (from_dut === ~flip) @(posedge aclk);
        repeat (BIT / 2) @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            f[i] = from_dut ^ flip;
            repeat (BIT) @(posedge aclk);
        end
    endtask : recv
endmodule : asr_peer

// File: tb/tb_top.sv
`timescale 1ns/10ps
`include "asr_consts.svh"
module tb_top;
    import asr_pkg::*;
    localparam int BIT = 32;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rx_line;
    logic awready, wready, bvalid, arready, rvalid, in_en, out_pin, out_oe, tx_irq, rx_irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int failures, tests_run;
    asr_core #(.ADDR_W(8)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .serial_in_pin(rx_line), .serial_in_en(in_en), .serial_out_pin(out_pin),
        .serial_out_oe(out_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
    asr_peer #(.BIT(BIT)) i_peer (.aclk(aclk), .from_dut(out_pin), .to_dut(rx_line));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic a = 1'b1, w = 1'b1;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        wdata <= 32'(d);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            a &= !awready;
            w &= !wready;
        end while (a || w);
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    function automatic logic [10:0] frame(input logic [8:0] v, input logic nine, input logic s);
        return nine ? {s, v, 1'b0} : {1'b0, s, v[7:0], 1'b0};
    endfunction : frame
    task automatic complete_run();
        $display("Compared %0d, mismatched %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    initial begin
        repeat (40000) @(posedge aclk);
        failures++;
        complete_run();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [10:0] g;
        logic [8:0] v, u;
        int n;
        realtime t0;
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hF;
        aresetn = 1'b0;
        void'($urandom(65692));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ASR_IDX_STAT1, d, r);
        check(d, 32'h000000C0);
        rd(6'h10, d, r);
        check(32'(r), 32'(`ASR_SLVERR));
        wr(`ASR_IDX_BAUD, 8'h01);
        for (int m = 0; m < 4; m++) begin
            n = m[0] ? 11 : 10;
            v = 9'($urandom);
            wr(`ASR_IDX_CTRL2, 8'h00);
            wr(`ASR_IDX_CTRL1, {2'b01, m[1], m[0], 4'h0});
            wr(`ASR_IDX_CTRL3, {1'b0, v[8], 6'h00});
            wr(`ASR_IDX_CTRL2, 8'h0C);
            rd(`ASR_IDX_STAT1, d, r);
            wr(`ASR_IDX_DATA, v[7:0]);
            t0 = $realtime;
            rd(`ASR_IDX_STAT1, d, r);
            check(32'(d[7]), 32'h0);
            i_peer.recv(m[1], n, g);
            check(32'(g), 32'(frame(v, m[0], 1'b1)));
            check(32'($realtime - t0 >= (2 * n * BIT + BIT / 2 - 20) * 5.0), 32'h1);
            repeat (BIT) @(posedge aclk);
            rd(`ASR_IDX_STAT1, d, r);
            check(32'(d[7:6]), 32'h3);
        end
        $display("Transmit frames done");
        wr(`ASR_IDX_CTRL1, 8'h40);
        wr(`ASR_IDX_CTRL2, 8'h4C);
        rd(`ASR_IDX_STAT1, d, r);
        check(32'(tx_irq), 32'h1);
        wr(`ASR_IDX_CTRL2, 8'h2C);
        rd(`ASR_IDX_STAT1, d, r);
        check(32'(tx_irq), 32'h0);
        for (int k = 0; k < 4; k++) begin
            v = (k == 3) ? 9'h000 : 9'($urandom) | 9'(k == 2);
            u = 9'($urandom);
            n = (k == 1) ? 11 : 10;
            wr(`ASR_IDX_CTRL1, (k == 1) ? 8'h50 : 8'h40);
            wr(`ASR_IDX_CTRL3, {1'b0, u[8], 6'h00});
            rd(`ASR_IDX_STAT1, d, r);
            wr(`ASR_IDX_DATA, u[7:0]);
            fork
                i_peer.send(frame(v, k == 1, k < 2), n);
                i_peer.recv(1'b0, n, g);
            join
            check(32'(g), 32'(frame(u, k == 1, 1'b1)));
            rd(`ASR_IDX_CTRL3, d, r);
            check(32'(d[7]), 32'((k == 3) ? 1'b0 : (k == 1) ? v[8] : v[7]));
            rd(`ASR_IDX_STAT2, d, r);
            check(32'(d[1]), 32'(k == 3));
            rd(`ASR_IDX_STAT1, d, r);
            check(d & 32'h22, (k < 2) ? 32'h20 : 32'h22);
            check(32'(rx_irq), 32'h1);
            rd(`ASR_IDX_DATA, d, r);
            check(d, 32'(v[7:0]));
        end
        $display("Receive frames done");
        wr(`ASR_IDX_CTRL2, 8'h0D);
        while (out_pin !== 1'b0) @(posedge aclk);
        repeat (15 * BIT) @(posedge aclk);
        check(32'(out_pin), 32'h0);
        wr(`ASR_IDX_CTRL2, 8'h0C);
        for (int i = 0; i < 12 * BIT && out_pin !== 1'b1; i++) @(posedge aclk);
        check(32'(out_pin), 32'h1);
        wr(`ASR_IDX_CTRL1, 8'h00);
        rd(`ASR_IDX_STAT1, d, r);
        check(32'({out_oe, in_en}), 32'h0);
        $display("Break and release done");
        complete_run();
    end
endmodule : tb_top
